/* File: hdl/lpm_defs.svh */
// Offsets, field positions, reset values and warm-up counts of the power-mode controller.
// Assumes a 32-bit classic Wishbone bus with byte addresses and 8-bit registers in lane 0.
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

// Register byte offsets
`define LPM_OFS_SC1       8'h00
`define LPM_OFS_SC2       8'h04
`define LPM_OFS_KEY       8'h08
`define LPM_OFS_STAT      8'h0C

// system_control_one fields
`define LPM_SC1_HALT      7
`define LPM_SC1_RELEASE_METHOD      6
`define LPM_SC1_RESUME_MODE_SELECT      5
`define LPM_SC1_WUT_HI    3
`define LPM_SC1_WUT_LO    2

// system_control_two fields
`define LPM_SC2_HF        7
`define LPM_SC2_LF        6
`define LPM_SC2_SYSCK     5
`define LPM_SC2_CPUH      4

// Reset values
`define LPM_SC1_RST       8'h00
`define LPM_SC2_RST       8'h80
`define LPM_KEY_RST       4'h0

// Warm-up counts in cycles of the restarted clock
`define LPM_WARM_F0       18'h30000
`define LPM_WARM_F1       18'h10000
`define LPM_WARM_F2       18'h0C000
`define LPM_WARM_F3       18'h04000
`define LPM_WARM_S0       18'h06000
`define LPM_WARM_S1       18'h02000
`define LPM_WARM_S2       18'h000C0
`define LPM_WARM_S3       18'h00040

`endif

/* File: hdl/lpm_pkg.sv */
// Types shared by the power-mode controller.
// Assumes lpm_defs.svh supplies the numeric constants.
`default_nettype none

package lpm_pkg;

    typedef enum logic [1:0] {
        LPM_RUN   = 2'b00,
        LPM_STOP  = 2'b01,
        LPM_WARM  = 2'b10,
        LPM_CHALT = 2'b11
    } lpm_state_t;

    typedef struct packed {
        logic hf_osc_on;
        logic lf_osc_on;
        logic core_clk_en;
        logic periph_clk_en;
        logic wdt_run;
        logic divider_clear;
    } lpm_ctl_t;

    typedef struct packed {
        lpm_state_t  st;
        logic        release_method;
        logic        resume_mode_select;
        logic [1:0]  warmup_select;
        logic        hf;
        logic        lf;
        logic        sysck;
        logic        cpuh;
        logic [3:0]  keyen;
        logic        eff_level;
        logic [17:0] cnt;
        logic        wk1;
        logic        wk2;
        logic        wk3;
        logic [3:0]  key1;
        logic [3:0]  key2;
        logic        rp1;
        logic        rp2;
        logic        ack;
        logic [31:0] dat;
        lpm_ctl_t    ctl;
        logic        service_int;
        logic        resume_next;
        logic        core_reset;
    } lpm_regs_t;

endpackage

`default_nettype wire

/* File: hdl/lpm_ctrl.sv */
// Power-mode controller: oscillator-off halt, wake, warm-up and CPU-halt modes.
// Assumes a classic Wishbone master on mclk and an interrupt controller on the same clock.
//
// What this block does
// (RULE1) Halt-start bit write enters oscillator-off halt
// (RULE2) Halt stops oscillators, freezes all, keeps state
// (RULE3) Prescaler and divider held cleared during halt
// (RULE4) After warm-up, resume at next instruction
// (RULE5) release_method one level wake, zero edge
// (RULE6) Level wake: pin high or enabled key low
// (RULE7) Level wake present at entry: warm-up immediately
// (RULE8) Software checks wake pin low before halting
// (RULE9) Pin low during warm-up never re-halts
// (RULE10) Edge-to-level switch waits for rising edge
// (RULE11) Edge mode halts even with pin high
// (RULE12) Restart oscillators matching the resumed mode
// (RULE13) Warm-up keeps everything halted, four lengths per resume mode
// (RULE14) Warm-up timed by dividing restarted clock
// (RULE15) Reset pin low ends halt, resets
// (RULE16) Software masks interrupts around the halt
// (RULE17) CPU-halt stops CPU and watchdog only
// (RULE18) Software enables wake interrupts, then requests
// (RULE19) Release clears cpu_halt_request, resumes prior mode
// (RULE20) Reset pin ends CPU-halt into fast_run_single
// (RULE21) Master disabled: wake without service, next instruction
// (RULE22) Master enabled: service interrupt, then continue
// (RULE23) Watchdog interrupt just before blocks CPU-halt
// (RULE24) warmup_select maps to fixed cycle counts
// (RULE25) resume_mode_select picks fast or slow resume
// (RULE26) Warm-up counter starts at zero, releases at count
`default_nettype none
`include "lpm_defs.svh"

module lpm_ctrl #(
    parameter logic [17:0] WARM_F0 = `LPM_WARM_F0,
    parameter logic [17:0] WARM_F1 = `LPM_WARM_F1,
    parameter logic [17:0] WARM_F2 = `LPM_WARM_F2,
    parameter logic [17:0] WARM_F3 = `LPM_WARM_F3,
    parameter logic [17:0] WARM_S0 = `LPM_WARM_S0,
    parameter logic [17:0] WARM_S1 = `LPM_WARM_S1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    // Pins
    input  wire logic             wake_pin,
    input  wire logic [3:0]       key_wakeup_inputs,
    input  wire logic             reset_pin_n,
    // Interrupt controller
    input  wire logic [7:0]       int_pending,
    input  wire logic [7:0]       individual_int_enable,
    input  wire logic             master_int_enable,
    input  wire logic             wdt_int_pending,
    // Clock and core control
    output var lpm_pkg::lpm_ctl_t ctl,
    output logic                  service_int,
    output logic                  resume_next,
    output logic                  core_reset
);

    localparam lpm_pkg::lpm_regs_t RST_S = '{
        st:          lpm_pkg::LPM_RUN,
        release_method:        1'(`LPM_SC1_RST >> `LPM_SC1_RELEASE_METHOD),
        resume_mode_select:        1'b0,
        warmup_select:         2'h0,
        hf:          1'b1,
        lf:          1'b0,
        sysck:       1'b0,
        cpuh:        1'b0,
        keyen:       `LPM_KEY_RST,
        eff_level:   1'b0,
        cnt:         18'h00000,
        wk1:         1'b0,
        wk2:         1'b0,
        wk3:         1'b0,
        key1:        4'hF,
        key2:        4'hF,
        rp1:         1'b1,
        rp2:         1'b1,
        ack:         1'b0,
        dat:         32'h00000000,
        ctl:         6'h2E,
        service_int: 1'b0,
        resume_next: 1'b0,
        core_reset:  1'b0
    };

    lpm_pkg::lpm_regs_t s;
    lpm_pkg::lpm_regs_t next_s;

    logic        acc;
    logic        wr;
    logic [7:0]  wd;
    logic        halt_go;
    logic        cpuh_go;
    logic        wake_rise;
    logic        key_wake;
    logic        lvl_wake;
    logic        int_wake;
    logic [17:0] limit;

    assign acc       = wb_cyc_i & wb_stb_i & ~s.ack;
    assign wr        = acc & wb_we_i & wb_sel_i[0];
    assign wd        = wb_dat_i[7:0];
    assign halt_go   = wr & (wb_adr_i == `LPM_OFS_SC1) & wd[`LPM_SC1_HALT];  // see (RULE1)
    assign cpuh_go   = wr & (wb_adr_i == `LPM_OFS_SC2) & wd[`LPM_SC2_CPUH];
    assign wake_rise = s.wk2 & ~s.wk3;
    assign key_wake  = |(~s.key2 & s.keyen);                                // see (RULE6)
    assign lvl_wake  = s.wk2 | key_wake;                                    // see (RULE6)
    assign int_wake  = |(int_pending & individual_int_enable);

    // Slow counts come from the low-frequency clock, fast ones from the high  see (RULE14) (RULE24)
    always_comb
    begin
        case ({s.resume_mode_select, s.warmup_select})
            3'b000:  limit = WARM_F0;
            3'b001:  limit = WARM_F1;
            3'b010:  limit = WARM_F2;
            3'b011:  limit = WARM_F3;
            3'b100:  limit = WARM_S0;
            3'b101:  limit = WARM_S1;
            3'b110:  limit = `LPM_WARM_S2;
            default: limit = `LPM_WARM_S3;
        endcase
    end

    always_comb
    begin
        logic wake_go;
        wake_go = 1'b0;
        next_s = s;
        next_s.service_int = 1'b0;
        next_s.resume_next = 1'b0;
        next_s.core_reset = 1'b0;
        next_s.ack = acc;
        // Pin synchronisers
        next_s.wk1 = wake_pin;
        next_s.wk2 = s.wk1;
        next_s.wk3 = s.wk2;
        next_s.key1 = key_wakeup_inputs;
        next_s.key2 = s.key1;
        next_s.rp1 = reset_pin_n;
        next_s.rp2 = s.rp1;

        // Level mode only takes hold after a rising edge  see (RULE10)
        if (!s.release_method)
            next_s.eff_level = 1'b0;
        else if (wake_rise)
            next_s.eff_level = 1'b1;

        if (acc && !wb_we_i)
        begin
            case (wb_adr_i)
                `LPM_OFS_SC1:  next_s.dat = {24'h0, 1'b0, s.release_method, s.resume_mode_select, 1'b0, s.warmup_select, 2'b00};
                `LPM_OFS_SC2:  next_s.dat = {24'h0, s.hf, s.lf, s.sysck, s.cpuh, 4'h0};
                `LPM_OFS_KEY:  next_s.dat = {28'h0, s.keyen};
                `LPM_OFS_STAT: next_s.dat = {28'h0, s.eff_level, s.wk2, s.st};
                default:       next_s.dat = 32'h00000000;
            endcase
        end

        if (wr)
        begin
            case (wb_adr_i)
                `LPM_OFS_SC1:
                begin
                    next_s.release_method = wd[`LPM_SC1_RELEASE_METHOD];                        // see (RULE5)
                    next_s.resume_mode_select = wd[`LPM_SC1_RESUME_MODE_SELECT];                        // see (RULE25)
                    next_s.warmup_select = wd[`LPM_SC1_WUT_HI:`LPM_SC1_WUT_LO];
                    if (!wd[`LPM_SC1_RELEASE_METHOD])
                        next_s.eff_level = 1'b0;                            // see (RULE10)
                end
                `LPM_OFS_SC2:
                begin
                    next_s.hf = wd[`LPM_SC2_HF];
                    next_s.lf = wd[`LPM_SC2_LF];
                    next_s.sysck = wd[`LPM_SC2_SYSCK];
                end
                `LPM_OFS_KEY:
                    next_s.keyen = wd[3:0];
                default:
                    next_s.keyen = next_s.keyen;
            endcase
        end

        case (s.st)
            lpm_pkg::LPM_RUN:
            begin
                if (halt_go)
                begin
                    if (s.eff_level && lvl_wake)
                        wake_go = 1'b1;                                     // see (RULE7)
                    else
                        next_s.st = lpm_pkg::LPM_STOP;                      // see (RULE1) (RULE11)
                end
                else if (cpuh_go && !wdt_int_pending)
                begin
                    next_s.st = lpm_pkg::LPM_CHALT;
                    next_s.cpuh = 1'b1;
                end
                // A watchdog interrupt already pending keeps the CPU running  see (RULE23)
            end
            lpm_pkg::LPM_STOP:
            begin
                // Edge mode ignores the key inputs by design  see (RULE5) (RULE6) (RULE11)
                if (s.eff_level ? lvl_wake : wake_rise)
                    wake_go = 1'b1;
            end
            lpm_pkg::LPM_WARM:
            begin
                // Pin level is not looked at here, so no re-entry  see (RULE9)
                next_s.cnt = s.cnt + 18'h00001;
                if (next_s.cnt == limit)
                begin
                    next_s.st = lpm_pkg::LPM_RUN;                           // see (RULE26)
                    next_s.resume_next = 1'b1;                              // see (RULE4)
                end
            end
            lpm_pkg::LPM_CHALT:
            begin
                if (int_wake)
                begin
                    next_s.st = lpm_pkg::LPM_RUN;
                    next_s.cpuh = 1'b0;                                     // see (RULE19)
                    next_s.service_int = master_int_enable;                 // see (RULE22)
                    next_s.resume_next = ~master_int_enable;                // see (RULE21)
                end
            end
            default:
                next_s.st = lpm_pkg::LPM_RUN;
        endcase

        if (wake_go)
        begin
            next_s.st = lpm_pkg::LPM_WARM;
            next_s.cnt = 18'h00000;                                         // see (RULE26)
            // Dual-clock resume keeps the low-frequency oscillator as it was  see (RULE12) (RULE25)
            next_s.hf = ~s.resume_mode_select;
            next_s.lf = s.resume_mode_select | s.lf;
            next_s.sysck = s.resume_mode_select;
        end

        // Reset pin wins over everything and lands in fast_run_single  see (RULE15) (RULE20)
        if (!s.rp2)
        begin
            next_s = RST_S;
            next_s.wk1 = wake_pin;
            next_s.wk2 = s.wk1;
            next_s.wk3 = s.wk2;
            next_s.key1 = key_wakeup_inputs;
            next_s.key2 = s.key1;
            next_s.rp1 = reset_pin_n;
            next_s.rp2 = s.rp1;
            next_s.ack = acc;
            next_s.core_reset = 1'b1;
        end

        // Outputs follow the next state so they leave flip-flops  see (RULE2) (RULE13) (RULE17)
        next_s.ctl.hf_osc_on = next_s.hf & (next_s.st != lpm_pkg::LPM_STOP);
        next_s.ctl.lf_osc_on = next_s.lf & (next_s.st != lpm_pkg::LPM_STOP);
        next_s.ctl.core_clk_en = next_s.st == lpm_pkg::LPM_RUN;
        next_s.ctl.periph_clk_en = (next_s.st == lpm_pkg::LPM_RUN) | (next_s.st == lpm_pkg::LPM_CHALT);
        next_s.ctl.wdt_run = next_s.st == lpm_pkg::LPM_RUN;
        next_s.ctl.divider_clear = next_s.st == lpm_pkg::LPM_STOP;          // see (RULE3)
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            s <= RST_S;
        else
            s <= next_s;
    end

    assign wb_dat_o    = s.dat;
    assign wb_ack_o    = s.ack;
    assign ctl         = s.ctl;
    assign service_int = s.service_int;
    assign resume_next = s.resume_next;
    assign core_reset  = s.core_reset;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_halt_entry: assert property (  // see (RULE1) (RULE11)
        s.st == lpm_pkg::LPM_RUN && halt_go && !(s.eff_level && lvl_wake) && s.rp2
        |=> s.st == lpm_pkg::LPM_STOP)
        else $error("halt not entered");
    a_stop_frozen: assert property (  // see (RULE2) (RULE3)
        s.st == lpm_pkg::LPM_STOP
        |-> !ctl.hf_osc_on && !ctl.lf_osc_on && !ctl.core_clk_en && !ctl.periph_clk_en && !ctl.wdt_run
        && ctl.divider_clear)
        else $error("halt does not freeze");
    a_level_imm: assert property (  // see (RULE7)
        s.st == lpm_pkg::LPM_RUN && halt_go && s.eff_level && lvl_wake && s.rp2
        |=> s.st == lpm_pkg::LPM_WARM && s.cnt == 18'h00000)
        else $error("level wake ignored");
    a_warm_end: assert property (  // see (RULE4) (RULE26)
        s.st == lpm_pkg::LPM_WARM && s.cnt + 18'h00001 == limit && s.rp2
        |=> s.st == lpm_pkg::LPM_RUN && resume_next && ctl.core_clk_en)
        else $error("warm-up end wrong");
    a_warm_hold: assert property (  // see (RULE9) (RULE13)
        s.st == lpm_pkg::LPM_WARM && s.cnt + 18'h00001 != limit && s.rp2
        |=> s.st == lpm_pkg::LPM_WARM && !ctl.core_clk_en)
        else $error("warm-up cut short");
    a_rst_pin: assert property (  // see (RULE15) (RULE20)
        !s.rp2
        |=> s.st == lpm_pkg::LPM_RUN && core_reset && s.hf && !s.sysck)
        else $error("reset pin ignored");
    a_edge_wait: assert property (  // see (RULE10)
        !s.eff_level && !wake_rise && s.rp2
        |=> !s.eff_level)
        else $error("level mode too early");
    a_key_edge: assert property (  // see (RULE11)
        s.st == lpm_pkg::LPM_STOP && !s.eff_level && !wake_rise && s.rp2
        |=> s.st == lpm_pkg::LPM_STOP)
        else $error("edge halt ended without edge");
    a_chalt_svc: assert property (  // see (RULE19) (RULE21) (RULE22)
        s.st == lpm_pkg::LPM_CHALT && int_wake && s.rp2
        |=> s.st == lpm_pkg::LPM_RUN && !s.cpuh && (service_int == $past(master_int_enable))
        && (resume_next != $past(master_int_enable)))
        else $error("cpu halt release wrong");
    a_chalt_run: assert property (  // see (RULE17)
        s.st == lpm_pkg::LPM_CHALT
        |-> !ctl.wdt_run && ctl.periph_clk_en && !ctl.core_clk_en)
        else $error("cpu halt clocks wrong");
    a_cpuh_flag: assert property (  // see (RULE19)
        s.cpuh == (s.st == lpm_pkg::LPM_CHALT))
        else $error("cpu halt request bit wrong");
    a_wdt_block: assert property (  // see (RULE23)
        s.st == lpm_pkg::LPM_RUN && cpuh_go && wdt_int_pending && !halt_go && s.rp2
        |=> s.st == lpm_pkg::LPM_RUN)
        else $error("halted over watchdog");
    a_resume_osc: assert property (  // see (RULE12)
        s.st == lpm_pkg::LPM_STOP ##1 s.st == lpm_pkg::LPM_WARM
        |-> ctl.hf_osc_on == !s.resume_mode_select && ctl.lf_osc_on == (s.resume_mode_select || $past(s.lf)))
        else $error("wrong oscillators");
    a_pulse_excl: assert property (  // see (RULE21) (RULE22)
        !(service_int && resume_next))
        else $error("service and resume together");

    c_stop_wake: cover property (s.st == lpm_pkg::LPM_STOP ##1 s.st == lpm_pkg::LPM_WARM);
    c_warm_done: cover property (s.st == lpm_pkg::LPM_WARM ##1 s.st == lpm_pkg::LPM_RUN);
    c_level_imm: cover property (s.st == lpm_pkg::LPM_RUN && halt_go && s.eff_level && lvl_wake);
    c_chalt_svc: cover property (s.st == lpm_pkg::LPM_CHALT ##1 service_int);

endmodule // lpm_ctrl

`default_nettype wire

/* File: verification/lpm_pins_model.sv */
// Far-side model: wake pin, key wake lines and reset pin.
// Assumes the bench calls its tasks; every change lands just after a rising mclk edge.
`default_nettype none

module lpm_pins_model (
    // Clock
    input  wire logic  mclk,
    // Pins
    output logic       wake_pin,
    output logic [3:0] key_wakeup_inputs,
    output logic       reset_pin_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // Keys idle released, pulled high
    initial
    begin
        wake_pin = 1'b0;
        key_wakeup_inputs = 4'hF;
        reset_pin_n = 1'b1;
    end

    task automatic drive(input logic w, input logic [3:0] k);
        @(posedge mclk);
        wake_pin <= w;
        key_wakeup_inputs <= k;
    endtask

    // Reset pin low for n edges, then released
    task automatic press_reset(input int n);
        @(posedge mclk);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge mclk);
        reset_pin_n <= 1'b1;
    endtask
endmodule // lpm_pins_model

`default_nettype wire

/* File: verification/test_low_power_mode_controller.sv */
// Self-checking bench for the power-mode controller.
// Assumes lpm_pins_model on the pins; warm-up counts shortened by parameters.
`default_nettype none
`include "lpm_defs.svh"

module test_low_power_mode_controller;
    timeunit 1ns;
    timeprecision 100ps;

    // Short fast counts keep the run brief; slow codes 2 and 3 are fixed
    localparam logic [17:0] LIM [8] = '{18'h8, 18'h6, 18'h4, 18'h3,
                                        18'h5, 18'h2, `LPM_WARM_S2, `LPM_WARM_S3};

    logic              mclk;
    logic              rst;
    logic              cyc;
    logic              stb;
    logic              we;
    logic [7:0]        adr;
    logic [31:0]       wdat;
    logic [31:0]       rdat;
    logic              ack;
    logic              wake;
    logic [3:0]        keys;
    logic              rpn;
    logic [7:0]        pend;
    logic [7:0]        ien;
    logic              mie;
    logic              wdti;
    lpm_pkg::lpm_ctl_t ctl;
    logic              service_int;
    logic              resume_next;
    logic              core_reset;
    int                fails;
    int                n_compared;
    int                i;
    logic [2:0]        c;

    lpm_ctrl #(.WARM_F0(LIM[0]), .WARM_F1(LIM[1]), .WARM_F2(LIM[2]),
               .WARM_F3(LIM[3]), .WARM_S0(LIM[4]), .WARM_S1(LIM[5])) dut (
        .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wake_pin(wake), .key_wakeup_inputs(keys),
        .reset_pin_n(rpn), .int_pending(pend), .individual_int_enable(ien),
        .master_int_enable(mie), .wdt_int_pending(wdti), .ctl(ctl),
        .service_int(service_int), .resume_next(resume_next),
        .core_reset(core_reset));

    lpm_pins_model far (.mclk(mclk), .wake_pin(wake), .key_wakeup_inputs(keys), .reset_pin_n(rpn));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic timeout();
        fails++;
        $display("unexpected at %0t: wait ran out", $time);
        end_sim();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Classic cycle: held until ack is sampled high at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        for (n = 0; n < 50; n++)
        begin
            @(posedge mclk);
            if (ack === 1'b1)
                break;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 50)
            timeout();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q & {24'h0, m}, {24'h0, e});
    endtask

    // Counts cycles with an oscillator up but the core clock held
    task automatic warm(input logic [17:0] lim, input logic [1:0] osc, input logic [5:0] fin);
        int n;
        int k;
        k = 0;
        for (n = 0; n < 400; n++)
        begin
            @(posedge mclk);
            if (resume_next === 1'b1)
                break;
            if (ctl.core_clk_en === 1'b0 && (ctl.hf_osc_on || ctl.lf_osc_on))
            begin
                if (k == 0)
                    chk(32'({ctl.hf_osc_on, ctl.lf_osc_on}), 32'(osc));
                k++;
            end
        end
        if (n == 400)
            timeout();
        if (lim != 18'h0)
            chk(32'(k), 32'(lim));
        chk(32'(ctl), 32'(fin));
    endtask

    task automatic rpin();
        fork
            far.press_reset(6);
            begin
                repeat (5) @(posedge mclk);
                chk(32'(core_reset), 32'h1);
            end
        join
        repeat (6) @(posedge mclk);
        chk(32'(ctl), 32'h2E);
        rdm(`LPM_OFS_SC2, 8'hFF, 8'h80);
    endtask

    // Release, then watch which pulse comes
    task automatic pulse(input logic [1:0] e);
        int n;
        logic [1:0] got;
        got = 2'b00;
        @(posedge mclk);
        pend <= 8'h01;
        for (n = 0; n < 20; n++)
        begin
            @(posedge mclk);
            got = got | {service_int === 1'b1, resume_next === 1'b1};
        end
        pend <= 8'h00;
        chk(32'(got), 32'(e));
    endtask

    initial
    begin
        fails = 0;
        n_compared = 0;
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        pend = 8'h00;
        ien = 8'h00;
        mie = 1'b0;
        wdti = 1'b0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rdm(`LPM_OFS_SC1, 8'hFF, 8'h00);
        rdm(`LPM_OFS_SC2, 8'hFF, 8'h80);
        rdm(`LPM_OFS_KEY, 8'hFF, 8'h00);
        chk(32'(ctl), 32'h2E);
        wr(8'h10, 8'hFF);
        rdm(8'h10, 8'hFF, 8'h00);
        rdm(`LPM_OFS_STAT, 8'h03, 8'h00);
        // Edge wake, every resume mode and warm-up code
        for (i = 0; i < 8; i++)
        begin
            c = i[2:0];
            far.drive(i == 0, 4'hF);
            // A rise still in the synchroniser would end the halt at once
            repeat (4) @(posedge mclk);
            wr(`LPM_OFS_SC1, {2'b10, c[2], 1'b0, c[1:0], 2'b00});
            repeat (4) @(posedge mclk);
            chk(32'(ctl), 32'h01);
            rdm(`LPM_OFS_STAT, 8'h03, 8'h01);
            far.drive(1'b0, 4'hF);
            repeat (3) @(posedge mclk);
            far.drive(1'b1, 4'hF);
            warm(LIM[i], c[2] ? 2'b01 : 2'b10, c[2] ? 6'h1E : 6'h2E);
            rdm(`LPM_OFS_SC1, 8'hEC, {2'b00, c[2], 1'b0, c[1:0], 2'b00});
            far.drive(1'b0, 4'hF);
        end
        wr(`LPM_OFS_SC1, 8'hA0);
        rpin();
        // Level wake only after a rising edge
        wr(`LPM_OFS_SC1, 8'h4C);
        rdm(`LPM_OFS_STAT, 8'h08, 8'h00);
        far.drive(1'b1, 4'hF);
        repeat (6) @(posedge mclk);
        rdm(`LPM_OFS_STAT, 8'h08, 8'h08);
        far.drive(1'b0, 4'hF);
        wr(`LPM_OFS_KEY, 8'h04);
        rdm(`LPM_OFS_STAT, 8'h04, 8'h00);
        wr(`LPM_OFS_SC1, 8'hCC);
        far.drive(1'b0, 4'hE);
        repeat (8) @(posedge mclk);
        rdm(`LPM_OFS_STAT, 8'h03, 8'h01);
        far.drive(1'b0, 4'hB);
        warm(LIM[3], 2'b10, 6'h2E);
        far.drive(1'b1, 4'hF);
        repeat (4) @(posedge mclk);
        wr(`LPM_OFS_SC1, 8'hC0);
        rdm(`LPM_OFS_STAT, 8'h03, 8'h02);
        far.drive(1'b0, 4'hF);
        warm(18'h0, 2'b10, 6'h2E);
        repeat (10) @(posedge mclk);
        rdm(`LPM_OFS_STAT, 8'h03, 8'h00);
        // CPU halt: master off, then on, wake source enabled first
        ien <= 8'h01;
        wr(`LPM_OFS_SC2, 8'h90);
        repeat (3) @(posedge mclk);
        chk(32'(ctl), 32'h24);
        pend <= 8'h02;
        repeat (6) @(posedge mclk);
        rdm(`LPM_OFS_STAT, 8'h03, 8'h03);
        pulse(2'b01);
        rdm(`LPM_OFS_SC2, 8'hFF, 8'h80);
        mie <= 1'b1;
        wr(`LPM_OFS_SC2, 8'h90);
        pulse(2'b10);
        rdm(`LPM_OFS_SC2, 8'h10, 8'h00);
        mie <= 1'b0;
        wdti <= 1'b1;
        wr(`LPM_OFS_SC2, 8'h90);
        repeat (3) @(posedge mclk);
        rdm(`LPM_OFS_STAT, 8'h03, 8'h00);
        wdti <= 1'b0;
        wr(`LPM_OFS_SC2, 8'h90);
        rpin();
        end_sim();
    end
endmodule // test_low_power_mode_controller

`default_nettype wire
